// file: inc/adcc_consts.vh
// Constants for the converter control and result interface
`ifndef ADCC_CONSTS_VH
`define ADCC_CONSTS_VH
// Byte offsets on the 8-bit internal bus
`define ADCC_OFS_RES0_HI 4'h0
`define ADCC_OFS_RES0_LO 4'h1
`define ADCC_OFS_RES1_HI 4'h2
`define ADCC_OFS_RES1_LO 4'h3
`define ADCC_OFS_RES2_HI 4'h4
`define ADCC_OFS_RES2_LO 4'h5
`define ADCC_OFS_RES3_HI 4'h6
`define ADCC_OFS_RES3_LO 4'h7
`define ADCC_OFS_CSR 4'h8
`define ADCC_OFS_TRG 4'h9
// Control/status fields
`define ADCC_CSR_END 7
`define ADCC_CSR_IE 6
`define ADCC_CSR_ST 5
`define ADCC_CSR_SCAN 4
`define ADCC_CSR_CKS 3
`define ADCC_CSR_GRP 2
`define ADCC_CSR_RESET 8'h00
`define ADCC_TRG_EN 7
`define ADCC_TRG_RESET 8'h7f
`define ADCC_TRG_RSVD 7'h7f
`define ADCC_RES_RESET 10'h000
// Conversion lengths in system states
`define ADCC_FIRST_SLOW 9'd266
`define ADCC_FIRST_FAST 9'd134
`define ADCC_NEXT_SLOW 9'd256
`define ADCC_NEXT_FAST 9'd128
`endif

// file: src/adcc_conv_timer.v
// Conversion length timer: counts one conversion and pulses at its end
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"
module adcc_conv_timer (
  input wire sys_clk,
  input wire reset_n,
  input wire run,
  input wire launch,
  input wire first,
  input wire fast,
  output wire done
);
  reg [8:0] cnt_q;
  reg [8:0] cnt_d;
  wire [8:0] len;
  // First conversion uses the longest start delay, later ones a fixed length
  assign len = first ? (fast ? `ADCC_FIRST_FAST : `ADCC_FIRST_SLOW) :
               (fast ? `ADCC_NEXT_FAST : `ADCC_NEXT_SLOW);
  // A fresh start hides the old count's end; gated by first, not launch, so no loop
  assign done = run && !first && (cnt_q == 9'h001);
  always @* begin
    cnt_d = cnt_q;
    if (!run) begin
      cnt_d = 9'h000;
    end else if (launch) begin
      cnt_d = len;
    end else if (cnt_q != 9'h000) begin
      cnt_d = cnt_q - 9'h001;
    end
  end
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule
`default_nettype wire

// file: src/adcc_top.v
// Control, status and result registers of the eight-channel converter
`timescale 1ns/1ps
`default_nettype none
`include "adcc_consts.vh"
// Function
// - Reset or standby clears control/status to zero.
// - End flag sets after single conversion or after full scan pass.
// - Writing 0 clears end flag only after it was read as 1.
// - DMA access to a result register clears the end flag.
// - End flag bit accepts only 0; writing 1 leaves it unchanged.
// - Interrupt enable gates the end-of-conversion request.
// - Start bit reads 1 while running; write 1 starts, 0 halts.
// - Single mode converts once then clears start bit.
// - Scan mode repeats over selected channels until start cleared.
// - With trigger enabled, falling trigger pin edge sets start bit.
// - With trigger disabled, trigger pin is ignored.
// - Mode bit: 0 single, 1 scan.
// - Speed select: 266 or 134 states maximum per conversion.
// - Group bit plus index select channel or scan range.
// - Trigger register resets to 7F; reserved bits read 1.
// - Upper byte read copies lower byte into the temporary latch.
// - Lower byte read returns the temporary latch.
// - Results are 10 bits left aligned; low six bits read 0.
// - Each result register serves same index of both groups.
// - Later scan conversions take fixed 256 or 128 states.
// - Scan start always begins at the group's first channel.
module adcc_top (
  input wire sys_clk,
  input wire reset_n,
  input wire standby,
  input wire [3:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  input wire bus_dma,
  output reg [7:0] bus_rdata,
  input wire ext_trigger_pin,
  input wire [9:0] conv_data,
  output wire [2:0] analog_channel,
  output wire sample_strobe,
  output wire end_of_conversion_irq
);
  //////////////////////////////////////////////////////////////////////////
  reg conversion_end_flag_q;
  reg end_irq_enable_q;
  reg convert_start_bit_q;
  reg scan_mode_q;
  reg conversion_speed_select_q;
  reg group_select_bit_q;
  reg channel_index_high_q;
  reg channel_index_low_q;
  reg ext_trigger_enable_q;
  reg flag_seen_q;
  reg trig_prev_q;
  reg running_q;
  reg first_q;
  reg [1:0] chan_q;
  reg [9:0] res_q [0:3];
  reg [7:0] temp_q;
  reg [7:0] rdata_d;
  wire clr_all;
  wire [7:0] csr_val;
  wire [7:0] trg_val;
  wire csr_wr;
  wire trg_wr;
  wire res_acc;
  wire res_hi_rd;
  wire res_lo_rd;
  wire [1:0] res_idx;
  wire trig_fall;
  wire start_req;
  wire launch;
  wire conv_done;
  wire pass_end;
  wire [1:0] last_chan;
  integer i;

  assign clr_all = !reset_n || standby;
  assign csr_val = {conversion_end_flag_q, end_irq_enable_q, convert_start_bit_q,
                    scan_mode_q, conversion_speed_select_q, group_select_bit_q,
                    channel_index_high_q, channel_index_low_q};
  assign trg_val = {ext_trigger_enable_q, `ADCC_TRG_RSVD};
  assign csr_wr = bus_wr && (bus_addr == `ADCC_OFS_CSR);
  assign trg_wr = bus_wr && (bus_addr == `ADCC_OFS_TRG);
  assign res_acc = (bus_rd || bus_wr) && !bus_addr[3];
  assign res_hi_rd = bus_rd && !bus_addr[3] && !bus_addr[0];
  assign res_lo_rd = bus_rd && !bus_addr[3] && bus_addr[0];
  assign res_idx = bus_addr[2:1];
  assign last_chan = {channel_index_high_q, channel_index_low_q};

  //////////////////////////////////////////////////////////////////////////
  // Trigger edge: pin is taken as synchronous to sys_clk
  assign trig_fall = trig_prev_q && !ext_trigger_pin && ext_trigger_enable_q;
  // Write of 1 into the start bit, or a qualified trigger edge
  assign start_req = (csr_wr && bus_wdata[`ADCC_CSR_ST]) || trig_fall;
  // A fresh start always reloads the first channel, even if already running
  assign launch = start_req || (running_q && conv_done && convert_start_bit_q &&
                  scan_mode_q);

  adcc_conv_timer u_timer (
    .sys_clk(sys_clk),
    .reset_n(reset_n && !standby),
    .run(convert_start_bit_q || start_req),
    .launch(launch),
    .first(start_req),
    .fast(start_req && csr_wr ? bus_wdata[`ADCC_CSR_CKS] : conversion_speed_select_q),
    .done(conv_done)
  );

  // Scan pass ends at the indexed channel; single mode ends every time
  assign pass_end = !scan_mode_q || (chan_q == last_chan);
  assign analog_channel = {group_select_bit_q,
                           scan_mode_q ? chan_q : last_chan};
  assign sample_strobe = conv_done && convert_start_bit_q;
  assign end_of_conversion_irq = conversion_end_flag_q && end_irq_enable_q;

  //////////////////////////////////////////////////////////////////////////
  // Control/status register
  always @(posedge sys_clk) begin
    if (clr_all) begin
      {conversion_end_flag_q, end_irq_enable_q, convert_start_bit_q, scan_mode_q,
       conversion_speed_select_q, group_select_bit_q, channel_index_high_q,
       channel_index_low_q} <= `ADCC_CSR_RESET;
      flag_seen_q <= 1'b0;
      running_q <= 1'b0;
      first_q <= 1'b0;
      chan_q <= 2'b00;
    end else begin
      if (csr_wr) begin
        end_irq_enable_q <= bus_wdata[`ADCC_CSR_IE];
        scan_mode_q <= bus_wdata[`ADCC_CSR_SCAN];
        conversion_speed_select_q <= bus_wdata[`ADCC_CSR_CKS];
        group_select_bit_q <= bus_wdata[`ADCC_CSR_GRP];
        channel_index_high_q <= bus_wdata[1];
        channel_index_low_q <= bus_wdata[0];
      end
      // Arm the clear only by reading the flag while set
      if (bus_rd && (bus_addr == `ADCC_OFS_CSR) && conversion_end_flag_q) begin
        flag_seen_q <= 1'b1;
      end
      // Clearing events first, setting last so a coincident set wins
      if ((csr_wr && !bus_wdata[`ADCC_CSR_END] && flag_seen_q) ||
          (bus_dma && res_acc)) begin
        conversion_end_flag_q <= 1'b0;
        flag_seen_q <= 1'b0;
      end
      if (conv_done && convert_start_bit_q && pass_end) begin
        conversion_end_flag_q <= 1'b1;
      end
      // Start bit: halt on written 0, self clear in single mode
      if (csr_wr && !bus_wdata[`ADCC_CSR_ST]) begin
        convert_start_bit_q <= 1'b0;
        running_q <= 1'b0;
      end
      if (conv_done && convert_start_bit_q && !scan_mode_q) begin
        convert_start_bit_q <= 1'b0;
        running_q <= 1'b0;
      end
      if (conv_done && convert_start_bit_q && scan_mode_q) begin
        chan_q <= pass_end ? 2'b00 : chan_q + 2'b01;
        first_q <= 1'b0;
      end
      if (start_req) begin
        convert_start_bit_q <= 1'b1;
        running_q <= 1'b1;
        first_q <= 1'b1;
        chan_q <= 2'b00;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Trigger register, edge history and result storage
  always @(posedge sys_clk) begin
    if (clr_all) begin
      ext_trigger_enable_q <= 1'b0;
      trig_prev_q <= 1'b1;
      temp_q <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        res_q[i] <= `ADCC_RES_RESET;
      end
    end else begin
      trig_prev_q <= ext_trigger_pin;
      if (trg_wr) begin
        ext_trigger_enable_q <= bus_wdata[`ADCC_TRG_EN];
      end
      if (sample_strobe) begin
        // Group 0 and group 1 of the same index share one register
        res_q[analog_channel[1:0]] <= conv_data;
      end
      if (res_hi_rd) begin
        temp_q <= {res_q[res_idx][1:0], 6'h00};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data is registered; it appears one cycle after the read strobe
  always @* begin
    rdata_d = 8'h00;
    if (res_hi_rd) begin
      rdata_d = res_q[res_idx][9:2];
    end else if (res_lo_rd) begin
      rdata_d = temp_q;
    end else if (bus_addr == `ADCC_OFS_CSR) begin
      rdata_d = csr_val;
    end else if (bus_addr == `ADCC_OFS_TRG) begin
      rdata_d = trg_val;
    end
  end

  always @(posedge sys_clk) begin
    if (clr_all) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      bus_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

// file: testbench/adcc_afe_model.sv
// Analog front end model: a fixed code for each input channel
`timescale 1ns/1ps
`default_nettype none
module adcc_afe_model (
  input wire logic [2:0] analog_channel,
  output logic [9:0] conv_data
);
  // Channel in the top bits, so a wrong result mux shows in the upper byte
  assign conv_data = {analog_channel, 7'h35};
endmodule
`default_nettype wire

// file: testbench/adcc_chk_chk.sv
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_chk (
  input wire sys_clk,
  input wire reset_n,
  input wire standby,
  input wire [3:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire [7:0] bus_wdata,
  input wire bus_dma,
  input wire [7:0] bus_rdata,
  input wire sample_strobe,
  input wire end_of_conversion_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || standby);
  ////////////////////////////////////////
  chk_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data moved without a read");
  chk_trg_reserved: assert property (bus_rd && bus_addr == 4'h9 |=> bus_rdata[6:0] == 7'h7f)
    else $error("trigger reserved bits not ones");
  chk_lo_zero: assert property (bus_rd && bus_addr < 4'h8 && bus_addr[0] |=> bus_rdata[5:0] == 6'h00)
    else $error("low result bits not zero");
  chk_irq_rise: assert property ($rose(end_of_conversion_irq) |-> $past(sample_strobe || bus_wr))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(end_of_conversion_irq) |->
    $past(bus_wr || bus_dma || !reset_n || standby))
    else $error("irq fell without cause");
  chk_dma_clear: assert property (bus_dma && (bus_rd || bus_wr) && !bus_addr[3] && !sample_strobe
    |=> !end_of_conversion_irq)
    else $error("dma access left flag set");
  chk_strobe_gap: assert property (sample_strobe |=> !sample_strobe [*8])
    else $error("conversions too close");
  chk_csr_rw: assert property (bus_wr && bus_addr == 4'h8 && !bus_wdata[5] ##1 bus_rd && bus_addr == 4'h8
    |=> bus_rdata[6:0] == $past(bus_wdata[6:0], 2))
    else $error("control bits not read back");
  cover property (sample_strobe);
  cover property (end_of_conversion_irq);
  cover property (bus_dma && bus_rd);
endmodule
bind adcc_top adcc_chk u_chk (.sys_clk, .reset_n, .standby, .bus_addr, .bus_rd, .bus_wr,
  .bus_wdata, .bus_dma, .bus_rdata, .sample_strobe, .end_of_conversion_irq);
`default_nettype wire

// file: testbench/test_adcc_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module test_adcc_top;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  logic [3:0] bus_addr = 4'h0;
  logic bus_rd = 1'b0;
  logic bus_wr = 1'b0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_dma = 1'b0;
  logic ext_trigger_pin = 1'b1;
  wire [7:0] bus_rdata;
  wire [9:0] conv_data;
  wire [2:0] analog_channel;
  wire sample_strobe;
  wire end_of_conversion_irq;
  int n_errors = 0;
  int checks_done = 0;
  int n;
  logic [2:0] ch;
  adcc_top DUT (.sys_clk, .reset_n, .standby, .bus_addr, .bus_rd, .bus_wr, .bus_wdata,
    .bus_dma, .bus_rdata, .ext_trigger_pin, .conv_data, .analog_channel, .sample_strobe,
    .end_of_conversion_irq);
  adcc_afe_model u_afe (.analog_channel, .conv_data);
  initial forever #2 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches %0d of %0d checks", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    bus_addr = a;
    bus_wdata = v;
    bus_wr = 1'b1;
    @(negedge sys_clk);
    bus_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge sys_clk);
    bus_rd = 1'b0;
    check({2'b00, bus_rdata}, {2'b00, exp});
  endtask
  // Counts cycles to the next strobe, then lets the storing edge land
  task automatic wait_strobe(output int k);
    k = 1;
    do begin
      @(negedge sys_clk);
      k++;
    end while (sample_strobe !== 1'b1 && k < 400);
    ch = analog_channel;
    @(negedge sys_clk);
    if (k >= 400) begin
      n_errors++;
      final_report();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h7f);
    rd(4'h0, 8'h00);
    rd(4'hc, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_single();
    wr(4'h8, 8'h61);
    rd(4'h8, 8'h61);
    wait_strobe(n);
    check({9'h0, n <= 266}, 10'h1);
    check({7'h0, ch}, 10'h1);
    check({9'h0, end_of_conversion_irq}, 10'h1);
    rd(4'h8, 8'hc1);
    rd(4'h2, 8'h2d);
    rd(4'h3, 8'h40);
    wr(4'h8, 8'h41);
    rd(4'h8, 8'h41);
    check({9'h0, end_of_conversion_irq}, 10'h0);
    $display("test single done");
  endtask
  task automatic t_flag_guard();
    wr(4'h8, 8'h20);
    wait_strobe(n);
    // Clear attempt with no read of the set flag before it
    wr(4'h8, 8'h00);
    rd(4'h8, 8'h80);
    wr(4'h8, 8'h80);
    rd(4'h8, 8'h80);
    check({9'h0, end_of_conversion_irq}, 10'h0);
    bus_dma = 1'b1;
    rd(4'h0, 8'h0d);
    bus_dma = 1'b0;
    rd(4'h8, 8'h00);
    $display("test flag guard done");
  endtask
  task automatic t_scan();
    wr(4'h9, 8'hff);
    rd(4'h9, 8'hff);
    wr(4'h8, 8'h1e);
    ext_trigger_pin = 1'b0;
    wait_strobe(n);
    check({7'h0, ch}, 10'h4);
    ext_trigger_pin = 1'b1;
    wait_strobe(n);
    check({7'h0, ch}, 10'h5);
    check(n[9:0], 10'd128);
    wait_strobe(n);
    check({7'h0, ch}, 10'h6);
    rd(4'h8, 8'hbe);
    wait_strobe(n);
    check({7'h0, ch}, 10'h4);
    standby = 1'b1;
    repeat (2) @(negedge sys_clk);
    standby = 1'b0;
    rd(4'h8, 8'h00);
    rd(4'h9, 8'h7f);
    $display("test scan done");
  endtask
  task automatic t_trig_off();
    ext_trigger_pin = 1'b0;
    repeat (300) @(negedge sys_clk);
    rd(4'h8, 8'h00);
    $display("test trigger off done");
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    reset_n = 1'b1;
    t_reset();
    t_single();
    t_flag_guard();
    t_scan();
    t_trig_off();
    final_report();
  end
endmodule
`default_nettype wire
